// file: src/acd_datapath.sv
`timescale 1ns/10ps
module acd_datapath (
	// Clock and reset.
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	// Instruction in.
	input  wire logic                      cmdValid,
	output logic                           cmdReady,
	input  wire acd_pkg::acd_cmd_t         cmd,
	// Results.
	output acd_pkg::acd_res_t              res,
	output logic [acd_pkg::WORD_W-1:0]     regA,
	output logic [acd_pkg::WORD_W-1:0]     regQ,
	output logic                           overflowFlag
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations.

	logic [acd_pkg::WORD_W-1:0]  a_r;
	logic [acd_pkg::WORD_W-1:0]  a_nxt;
	logic [acd_pkg::WORD_W-1:0]  q_r;
	logic [acd_pkg::WORD_W-1:0]  q_nxt;
	logic                        ovf_r;
	logic                        ovf_nxt;
	acd_pkg::acd_state_t         state_r;
	acd_pkg::acd_state_t         state_nxt;
	acd_pkg::acd_op_t            shOp_r;
	acd_pkg::acd_op_t            shOp_nxt;
	logic [acd_pkg::CNT_W-1:0]   shCnt_r;
	logic [acd_pkg::CNT_W-1:0]   shCnt_nxt;
	acd_pkg::acd_res_t           res_r;
	acd_pkg::acd_res_t           res_nxt;

	logic [acd_pkg::WORD_W-1:0]  addInA;
	logic [acd_pkg::WORD_W-1:0]  addInB;
	logic [acd_pkg::WORD_W-1:0]  addSum;
	logic                        addOvf;
	logic [acd_pkg::WORD_W-1:0]  fieldExt;
	logic                        accept;

	logic [acd_pkg::DWORD_W-1:0] mulMag;
	logic [acd_pkg::DWORD_W-1:0] mulProd;
	logic [acd_pkg::DWORD_W-1:0] divMagD;
	logic [acd_pkg::WORD_W-1:0]  divMagS;
	logic [acd_pkg::DWORD_W-1:0] divQuo;
	logic [acd_pkg::DWORD_W-1:0] divRem;
	logic                        divOvf;

	////////////////////////////////////////////////////////////////////////////
	// Helper functions.

	// Magnitude of a ones'-complement word.
	function automatic logic [acd_pkg::WORD_W-1:0] mag16(input logic [acd_pkg::WORD_W-1:0] w);
		mag16 = w[acd_pkg::SIGN_BIT] ? ~w : w;
	endfunction : mag16

	// Applies a sign to a magnitude, complementing for negative.
	function automatic logic [acd_pkg::WORD_W-1:0] sgn16(input logic neg,
		input logic [acd_pkg::WORD_W-1:0] m);
		sgn16 = neg ? ~m : m;
	endfunction : sgn16

	////////////////////////////////////////////////////////////////////////////
	// Shared ones'-complement adder.

	// The adder inputs are steered by the operation being accepted.
	always_comb begin
		addInA = a_r;
		addInB = cmd.operand;
		unique case (cmd.op)
			acd_pkg::OP_ADD_TO_Q:        addInA = q_r;
			acd_pkg::OP_INCREASE_A:      addInB = fieldExt;
			acd_pkg::OP_INCREASE_Q: begin
				addInA = q_r;
				addInB = fieldExt;
			end
			acd_pkg::OP_REPLACE_ADD_ONE: begin
				addInA = cmd.operand;
				addInB = acd_pkg::WORD_ONE;
			end
			acd_pkg::OP_SUBTRACT:        addInB = ~cmd.operand;
			acd_pkg::OP_SUM_A_Q:         addInB = q_r;
			default: begin
				addInA = a_r;
				addInB = cmd.operand;
			end
		endcase
	end

	acd_oc_adder #(
		.WIDTH    (acd_pkg::WORD_W)
	) u_adder (
		.addendA  (addInA),
		.addendB  (addInB),
		.sum      (addSum),
		.overflow (addOvf)
	);

	////////////////////////////////////////////////////////////////////////////
	// Multiply and divide on magnitudes.

	// Sign of the field is replicated, which is also a valid ones'-complement extension.
	assign fieldExt = {{(acd_pkg::WORD_W-acd_pkg::FIELD_W){cmd.field[acd_pkg::FIELD_W-1]}},
		cmd.field};

	// Product of magnitudes, complemented whole when the signs differ.
	always_comb begin
		mulMag  = {16'h0000, mag16(a_r)} * {16'h0000, mag16(cmd.operand)};
		mulProd = (a_r[acd_pkg::SIGN_BIT] ^ cmd.operand[acd_pkg::SIGN_BIT]) ? ~mulMag : mulMag;
	end

	// Quotient must fit in fifteen magnitude bits, and the divisor must not be zero.
	always_comb begin
		divMagD = q_r[acd_pkg::SIGN_BIT] ? ~{q_r, a_r} : {q_r, a_r};
		divMagS = mag16(cmd.operand);
		divOvf  = (divMagS == acd_pkg::WORD_ZERO) ||
			(divMagD[acd_pkg::DSIGN_BIT-1:acd_pkg::MAG_W] >= divMagS);
		divQuo  = acd_pkg::DWORD_ZERO;
		divRem  = acd_pkg::DWORD_ZERO;
		if (!divOvf) begin
			divQuo = divMagD / {16'h0000, divMagS};
			divRem = divMagD % {16'h0000, divMagS};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Instruction sequencing and register updates.

	assign cmdReady = (state_r == acd_pkg::ST_IDLE);
	assign accept   = cmdValid && cmdReady;

	// Next-state logic for registers, overflow, shift sequencer and results.
	always_comb begin
		a_nxt     = a_r;
		q_nxt     = q_r;
		ovf_nxt   = ovf_r;
		state_nxt = state_r;
		shOp_nxt  = shOp_r;
		shCnt_nxt = shCnt_r;
		res_nxt   = '0;
		unique case (state_r)
			acd_pkg::ST_IDLE: begin
				if (accept) begin
					res_nxt.done = 1'b1;
					unique case (cmd.op)
						acd_pkg::OP_SKIP_A_NEGATIVE:
							res_nxt.skip = a_r[acd_pkg::SIGN_BIT];
						acd_pkg::OP_SKIP_Q_NEGATIVE:
							res_nxt.skip = q_r[acd_pkg::SIGN_BIT];
						acd_pkg::OP_SHIFT_A_LEFT, acd_pkg::OP_SHIFT_Q_LEFT,
						acd_pkg::OP_SHIFT_A_RIGHT, acd_pkg::OP_SHIFT_Q_RIGHT,
						acd_pkg::OP_LONG_LEFT, acd_pkg::OP_LONG_RIGHT: begin
							// A zero count completes at once with nothing moved.
							if (cmd.count != acd_pkg::CNT_ZERO) begin
								res_nxt.done = 1'b0;
								state_nxt    = acd_pkg::ST_SHIFT;
								shOp_nxt     = cmd.op;
								shCnt_nxt    = cmd.count;
							end
						end
						acd_pkg::OP_ENTER_A_IMMED:
							a_nxt = fieldExt;
						acd_pkg::OP_ENTER_Q_IMMED:
							q_nxt = fieldExt;
						acd_pkg::OP_AND_A:
							a_nxt = a_r & cmd.operand;
						acd_pkg::OP_XOR_A:
							a_nxt = a_r ^ cmd.operand;
						acd_pkg::OP_ADD_A, acd_pkg::OP_INCREASE_A, acd_pkg::OP_SUBTRACT: begin
							a_nxt   = addSum;
							ovf_nxt = ovf_r | addOvf;
						end
						acd_pkg::OP_ADD_TO_Q, acd_pkg::OP_INCREASE_Q: begin
							q_nxt   = addSum;
							ovf_nxt = ovf_r | addOvf;
						end
						acd_pkg::OP_REPLACE_ADD_ONE: begin
							res_nxt.storeValid = 1'b1;
							res_nxt.storeData  = addSum;
							ovf_nxt            = ovf_r | addOvf;
						end
						acd_pkg::OP_SKIP_ON_OVERFLOW: begin
							res_nxt.skip = ovf_r;
							ovf_nxt      = 1'b0;
						end
						acd_pkg::OP_SKIP_NO_OVERFLOW:
							res_nxt.skip = !ovf_r;
						acd_pkg::OP_MULTIPLY_INTEGER: begin
							q_nxt = mulProd[acd_pkg::DWORD_W-1:acd_pkg::WORD_W];
							a_nxt = mulProd[acd_pkg::WORD_W-1:0];
						end
						acd_pkg::OP_DIVIDE_INTEGER: begin
							// On overflow the registers keep their contents.
							ovf_nxt = ovf_r | divOvf;
							if (!divOvf) begin
								a_nxt = sgn16(q_r[acd_pkg::SIGN_BIT] ^
									cmd.operand[acd_pkg::SIGN_BIT], divQuo[acd_pkg::WORD_W-1:0]);
								q_nxt = sgn16(q_r[acd_pkg::SIGN_BIT], divRem[acd_pkg::WORD_W-1:0]);
							end
						end
						acd_pkg::OP_STORE_PARITY: begin
							res_nxt.storeValid = 1'b1;
							res_nxt.storeData  = {{(acd_pkg::WORD_W-1){1'b0}}, ^a_r};
						end
						acd_pkg::OP_SET_ONES: begin
							if (cmd.destA) a_nxt = acd_pkg::WORD_ONES;
							if (cmd.destQ) q_nxt = acd_pkg::WORD_ONES;
						end
						acd_pkg::OP_ZERO_REGISTERS: begin
							if (cmd.destA) a_nxt = acd_pkg::WORD_ZERO;
							if (cmd.destQ) q_nxt = acd_pkg::WORD_ZERO;
						end
						acd_pkg::OP_COPY_A, acd_pkg::OP_COPY_Q,
						acd_pkg::OP_COPY_NOT_A, acd_pkg::OP_COPY_NOT_Q: begin
							// Source is taken before either destination changes.
							if (cmd.destA) a_nxt = copySrc(cmd.op, a_r, q_r);
							if (cmd.destQ) q_nxt = copySrc(cmd.op, a_r, q_r);
						end
						acd_pkg::OP_SUM_A_Q: begin
							if (cmd.destA) a_nxt = addSum;
							if (cmd.destQ) q_nxt = addSum;
							ovf_nxt = ovf_r | addOvf;
						end
						acd_pkg::OP_XOR_A_Q: begin
							if (cmd.destA) a_nxt = a_r ^ q_r;
							if (cmd.destQ) q_nxt = a_r ^ q_r;
						end
						default: res_nxt.done = 1'b1;
					endcase
				end
			end
			acd_pkg::ST_SHIFT: begin
				// One place per cycle; overflow is never touched here.
				unique case (shOp_r)
					acd_pkg::OP_SHIFT_A_LEFT:
						a_nxt = {a_r[acd_pkg::SIGN_BIT-1:0], a_r[acd_pkg::SIGN_BIT]};
					acd_pkg::OP_SHIFT_Q_LEFT:
						q_nxt = {q_r[acd_pkg::SIGN_BIT-1:0], q_r[acd_pkg::SIGN_BIT]};
					acd_pkg::OP_SHIFT_A_RIGHT:
						a_nxt = {a_r[acd_pkg::SIGN_BIT], a_r[acd_pkg::SIGN_BIT:1]};
					acd_pkg::OP_SHIFT_Q_RIGHT:
						q_nxt = {q_r[acd_pkg::SIGN_BIT], q_r[acd_pkg::SIGN_BIT:1]};
					acd_pkg::OP_LONG_LEFT: begin
						a_nxt = {a_r[acd_pkg::SIGN_BIT-1:0], q_r[acd_pkg::SIGN_BIT]};
						q_nxt = {q_r[acd_pkg::SIGN_BIT-1:0], a_r[acd_pkg::SIGN_BIT]};
					end
					acd_pkg::OP_LONG_RIGHT: begin
						a_nxt = {a_r[acd_pkg::SIGN_BIT], a_r[acd_pkg::SIGN_BIT:1]};
						q_nxt = {a_r[0], q_r[acd_pkg::SIGN_BIT:1]};
					end
					default: state_nxt = acd_pkg::ST_IDLE;
				endcase
				shCnt_nxt = shCnt_r - acd_pkg::CNT_ONE;
				if (shCnt_r == acd_pkg::CNT_ONE) begin
					state_nxt    = acd_pkg::ST_IDLE;
					res_nxt.done = 1'b1;
				end
			end
			default: state_nxt = acd_pkg::ST_IDLE;
		endcase
	end

	// Picks the source word of a copy, complemented for the complementing forms.
	function automatic logic [acd_pkg::WORD_W-1:0] copySrc(input acd_pkg::acd_op_t op,
		input logic [acd_pkg::WORD_W-1:0] a, input logic [acd_pkg::WORD_W-1:0] q);
		unique case (op)
			acd_pkg::OP_COPY_Q:     copySrc = q;
			acd_pkg::OP_COPY_NOT_A: copySrc = ~a;
			acd_pkg::OP_COPY_NOT_Q: copySrc = ~q;
			default:                copySrc = a;
		endcase
	endfunction : copySrc

	////////////////////////////////////////////////////////////////////////////
	// State registers.

	// Synchronous reset clears the accumulators, overflow and sequencer.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			a_r     <= acd_pkg::WORD_ZERO;
			q_r     <= acd_pkg::WORD_ZERO;
			ovf_r   <= 1'b0;
			state_r <= acd_pkg::ST_IDLE;
			shOp_r  <= acd_pkg::OP_SHIFT_A_LEFT;
			shCnt_r <= acd_pkg::CNT_ZERO;
			res_r   <= '0;
		end else begin
			a_r     <= a_nxt;
			q_r     <= q_nxt;
			ovf_r   <= ovf_nxt;
			state_r <= state_nxt;
			shOp_r  <= shOp_nxt;
			shCnt_r <= shCnt_nxt;
			res_r   <= res_nxt;
		end
	end

	// Outputs come straight from the registers.
	assign regA         = a_r;
	assign regQ         = q_r;
	assign overflowFlag = ovf_r;
	assign res          = res_r;

endmodule : acd_datapath

// file: src/acd_oc_adder.sv
`timescale 1ns/10ps
module acd_oc_adder #(
	parameter int WIDTH = acd_pkg::WORD_W
) (
	// Operands.
	input  wire logic [WIDTH-1:0] addendA,
	input  wire logic [WIDTH-1:0] addendB,
	// Result.
	output logic      [WIDTH-1:0] sum,
	output logic                  overflow
);

	logic [WIDTH:0] raw;

	// Ones'-complement add: the carry out of the top is added back in at the bottom.
	always_comb begin
		raw      = {1'b0, addendA} + {1'b0, addendB};
		sum      = raw[WIDTH-1:0] + {{(WIDTH-1){1'b0}}, raw[WIDTH]};
		overflow = (addendA[WIDTH-1] == addendB[WIDTH-1]) && (sum[WIDTH-1] != addendA[WIDTH-1]);
	end

endmodule : acd_oc_adder

// file: src/acd_pkg.sv
package acd_pkg;

	// Data path widths.
	localparam int WORD_W  = 16;
	localparam int DWORD_W = 32;
	localparam int FIELD_W = 8;
	localparam int CNT_W   = 5;
	localparam int MAG_W   = 15;

	// Fixed word values.
	localparam logic [WORD_W-1:0]  WORD_ZERO  = 16'h0000;
	localparam logic [WORD_W-1:0]  WORD_ONES  = 16'hFFFF;
	localparam logic [WORD_W-1:0]  WORD_ONE   = 16'h0001;
	localparam logic [WORD_W-1:0]  MAG_LIMIT  = 16'h7FFF;
	localparam logic [DWORD_W-1:0] DWORD_ZERO = 32'h0000_0000;
	localparam logic [CNT_W-1:0]   CNT_ZERO   = 5'h00;
	localparam logic [CNT_W-1:0]   CNT_ONE    = 5'h01;

	// Bit positions.
	localparam int SIGN_BIT  = WORD_W - 1;
	localparam int DSIGN_BIT = DWORD_W - 1;

	// Operation codes.
	typedef enum logic [4:0] {
		OP_SKIP_A_NEGATIVE  = 5'h00,
		OP_SKIP_Q_NEGATIVE  = 5'h01,
		OP_SHIFT_A_LEFT     = 5'h02,
		OP_SHIFT_Q_LEFT     = 5'h03,
		OP_SHIFT_A_RIGHT    = 5'h04,
		OP_SHIFT_Q_RIGHT    = 5'h05,
		OP_LONG_LEFT        = 5'h06,
		OP_LONG_RIGHT       = 5'h07,
		OP_ENTER_A_IMMED    = 5'h08,
		OP_ENTER_Q_IMMED    = 5'h09,
		OP_AND_A            = 5'h0A,
		OP_ADD_A            = 5'h0B,
		OP_ADD_TO_Q         = 5'h0C,
		OP_INCREASE_A       = 5'h0D,
		OP_INCREASE_Q       = 5'h0E,
		OP_REPLACE_ADD_ONE  = 5'h0F,
		OP_SUBTRACT         = 5'h10,
		OP_SKIP_ON_OVERFLOW = 5'h11,
		OP_SKIP_NO_OVERFLOW = 5'h12,
		OP_MULTIPLY_INTEGER = 5'h13,
		OP_DIVIDE_INTEGER   = 5'h14,
		OP_STORE_PARITY     = 5'h15,
		OP_SET_ONES         = 5'h16,
		OP_ZERO_REGISTERS   = 5'h17,
		OP_COPY_A           = 5'h18,
		OP_COPY_Q           = 5'h19,
		OP_COPY_NOT_A       = 5'h1A,
		OP_COPY_NOT_Q       = 5'h1B,
		OP_SUM_A_Q          = 5'h1C,
		OP_XOR_A_Q          = 5'h1D,
		OP_XOR_A            = 5'h1E
	} acd_op_t;

	// Sequencer states.
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_SHIFT = 2'b01
	} acd_state_t;

	// One instruction as presented to the datapath.
	typedef struct packed {
		acd_op_t              op;
		logic [WORD_W-1:0]    operand;
		logic [FIELD_W-1:0]   field;
		logic [CNT_W-1:0]     count;
		logic                 destA;
		logic                 destQ;
	} acd_cmd_t;

	// Result of one instruction.
	typedef struct packed {
		logic                 done;
		logic                 skip;
		logic                 storeValid;
		logic [WORD_W-1:0]    storeData;
	} acd_res_t;

endpackage : acd_pkg

// file: testbench/acd_datapath_sva.sv
`timescale 1ns/10ps
module acd_datapath_sva (
	// Clock and reset.
	input wire logic                       clk,
	input wire logic                       rst_n,
	// Instruction in.
	input wire logic                       cmdValid,
	input wire logic                       cmdReady,
	input wire acd_pkg::acd_cmd_t          cmd,
	// Results.
	input wire acd_pkg::acd_res_t          res,
	input wire logic [acd_pkg::WORD_W-1:0] regA,
	input wire logic [acd_pkg::WORD_W-1:0] regQ,
	input wire logic                       overflowFlag
);
	// An instruction is taken where offer and ready meet.
	logic             take;
	acd_pkg::acd_op_t op;
	assign take = cmdValid && cmdReady;
	assign op = cmd.op;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// A two-place right shift keeps ready low for two cycles, then completes.
	sequence twoShiftTake;
		take && op == acd_pkg::OP_SHIFT_A_RIGHT && cmd.count == 5'h02;
	endsequence
	sequence twoShiftRun;
		!cmdReady ##1 !cmdReady ##1 (res.done && cmdReady);
	endsequence
	shift_timing_a: assert property (twoShiftTake |=> twoShiftRun)
		else $error("Two-place shift timing wrong.");
	skip_q_a: assert property (take && op == acd_pkg::OP_SKIP_Q_NEGATIVE |=>
		res.done && res.skip == $past(regQ[15])) else $error("Q sign skip wrong.");
	left_ovf_a: assert property (take && op inside {acd_pkg::OP_SHIFT_A_LEFT,
		acd_pkg::OP_SHIFT_Q_LEFT, acd_pkg::OP_LONG_LEFT} |=> $stable(overflowFlag))
		else $error("Left shift touched overflow.");
	shift_ovf_a: assert property (!cmdReady |=> $stable(overflowFlag))
		else $error("Overflow changed during a shift.");
	enter_a_a: assert property (take && op == acd_pkg::OP_ENTER_A_IMMED |=>
		regA == {{8{$past(cmd.field[7])}}, $past(cmd.field)}) else $error("Enter A wrong.");
	enter_q_a: assert property (take && op == acd_pkg::OP_ENTER_Q_IMMED |=>
		regQ == {{8{$past(cmd.field[7])}}, $past(cmd.field)}) else $error("Enter Q wrong.");
	and_a_a: assert property (take && op == acd_pkg::OP_AND_A |=>
		regA == ($past(regA) & $past(cmd.operand))) else $error("AND result wrong.");
	sov_clear_a: assert property (take && op == acd_pkg::OP_SKIP_ON_OVERFLOW |=>
		res.skip == $past(overflowFlag) && !overflowFlag) else $error("Overflow skip wrong.");
	sno_keep_a: assert property (take && op == acd_pkg::OP_SKIP_NO_OVERFLOW |=>
		res.skip != $past(overflowFlag) && $stable(overflowFlag)) else $error("No-overflow skip wrong.");
	ones_both_a: assert property (take && op == acd_pkg::OP_SET_ONES && cmd.destA && cmd.destQ
		|=> regA == '1 && regQ == '1) else $error("Set ones failed.");
	zero_both_a: assert property (take && op == acd_pkg::OP_ZERO_REGISTERS && cmd.destA
		&& cmd.destQ |=> regA == '0 && regQ == '0) else $error("Clear failed.");
endmodule : acd_datapath_sva

bind acd_datapath acd_datapath_sva i_sva (.clk(clk), .rst_n(rst_n), .cmdValid(cmdValid),
	.cmdReady(cmdReady), .cmd(cmd), .res(res), .regA(regA), .regQ(regQ),
	.overflowFlag(overflowFlag));

// file: testbench/acd_datapath_tb_top.sv
`timescale 1ns/10ps
module acd_datapath_tb_top;
	// Expected outcome of one instruction.
	typedef struct packed {
		logic [15:0] a;
		logic [15:0] q;
		logic        ovf;
		logic        skip;
		logic        sv;
		logic [15:0] sd;
	} acd_exp_t;
	logic              clk;
	logic              rst_n;
	logic              cmdValid;
	logic              cmdReady;
	acd_pkg::acd_cmd_t cmd;
	acd_pkg::acd_res_t res;
	logic [15:0]       regA;
	logic [15:0]       regQ;
	logic              overflowFlag;
	logic [15:0]       mA;
	logic [15:0]       mQ;
	logic              mOvf;
	logic [31:0]       lfsr;
	logic [15:0]       v;
	int                num_errors;
	int                checks;
	acd_exp_t          expQ[$];
	acd_exp_t          nowExp;
	acd_pkg::acd_op_t  o;

	acd_datapath i_dut (.clk(clk), .rst_n(rst_n), .cmdValid(cmdValid), .cmdReady(cmdReady),
		.cmd(cmd), .res(res), .regA(regA), .regQ(regQ), .overflowFlag(overflowFlag));

	// Free-running 125 MHz clock.
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Ones' complement add with end-around carry; top bit is the sign-change flag.
	function automatic logic [16:0] ocAdd(input logic [15:0] x, input logic [15:0] y);
		logic [16:0] s;
		s = {1'b0, x} + {1'b0, y};
		s[15:0] = s[15:0] + {15'h0000, s[16]};
		return {(x[15] == y[15]) && (s[15] != x[15]), s[15:0]};
	endfunction : ocAdd

	// Pseudo-random words from a shift register.
	function automatic logic [15:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr[15:0];
	endfunction : rnd

	function automatic acd_pkg::acd_cmd_t mk(input acd_pkg::acd_op_t op,
		input logic [15:0] val = 16'h0000, input logic [4:0] n = 5'h00,
		input logic [1:0] dst = 2'b11, input logic [7:0] f = 8'h00);
		return '{op, val, f, n, dst[1], dst[0]};
	endfunction : mk

	// Reference model: updates the expected registers and queues the outcome.
	task automatic model(input acd_pkg::acd_cmd_t c);
		acd_exp_t    e;
		logic [16:0] s;
		logic [31:0] d;
		logic [15:0] fx;
		logic [15:0] w;
		logic        wr;
		fx = {{8{c.field[7]}}, c.field};
		w = '0;
		e = '0;
		d = {mA, mQ};
		s = '0;
		wr = 1'b1;
		case (c.op)
			acd_pkg::OP_SKIP_A_NEGATIVE:  e.skip = mA[15];
			acd_pkg::OP_SKIP_Q_NEGATIVE:  e.skip = mQ[15];
			acd_pkg::OP_SHIFT_A_LEFT:     repeat (c.count) mA = {mA[14:0], mA[15]};
			acd_pkg::OP_SHIFT_Q_LEFT:     repeat (c.count) mQ = {mQ[14:0], mQ[15]};
			acd_pkg::OP_SHIFT_A_RIGHT:    repeat (c.count) mA = {mA[15], mA[15:1]};
			acd_pkg::OP_SHIFT_Q_RIGHT:    repeat (c.count) mQ = {mQ[15], mQ[15:1]};
			acd_pkg::OP_LONG_LEFT:        repeat (c.count) d = {d[30:0], d[31]};
			acd_pkg::OP_LONG_RIGHT:       repeat (c.count) d = {d[31], d[31:1]};
			acd_pkg::OP_ENTER_A_IMMED:    mA = fx;
			acd_pkg::OP_ENTER_Q_IMMED:    mQ = fx;
			acd_pkg::OP_AND_A:            mA = mA & c.operand;
			acd_pkg::OP_XOR_A:            mA = mA ^ c.operand;
			acd_pkg::OP_ADD_A:            s = ocAdd(mA, c.operand);
			acd_pkg::OP_ADD_TO_Q:         s = ocAdd(mQ, c.operand);
			acd_pkg::OP_INCREASE_A:       s = ocAdd(mA, fx);
			acd_pkg::OP_INCREASE_Q:       s = ocAdd(mQ, fx);
			acd_pkg::OP_SUBTRACT:         s = ocAdd(mA, ~c.operand);
			acd_pkg::OP_REPLACE_ADD_ONE:  s = ocAdd(c.operand, 16'h0001);
			acd_pkg::OP_SUM_A_Q:          s = ocAdd(mA, mQ);
			acd_pkg::OP_SKIP_ON_OVERFLOW: e.skip = mOvf;
			acd_pkg::OP_SKIP_NO_OVERFLOW: e.skip = !mOvf;
			acd_pkg::OP_MULTIPLY_INTEGER: {mQ, mA} = mA * c.operand;
			acd_pkg::OP_STORE_PARITY:     e.sd = {15'h0000, ^mA};
			default: ;
		endcase
		if (c.op inside {acd_pkg::OP_LONG_LEFT, acd_pkg::OP_LONG_RIGHT})
			{mA, mQ} = d;
		if (c.op == acd_pkg::OP_SKIP_ON_OVERFLOW)
			mOvf = 1'b0;
		// Divide overflows when the quotient needs more than fifteen bits; A and Q stay then.
		if (c.op == acd_pkg::OP_DIVIDE_INTEGER && (c.operand == 16'h0000 ||
				({mQ, mA} / c.operand) > 32'h0000_7fff))
			mOvf = 1'b1;
		else if (c.op == acd_pkg::OP_DIVIDE_INTEGER)
			{mQ, mA} = {16'({mQ, mA} % c.operand), 16'({mQ, mA} / c.operand)};
		if (c.op inside {acd_pkg::OP_REPLACE_ADD_ONE, acd_pkg::OP_STORE_PARITY})
			e.sv = 1'b1;
		if (c.op == acd_pkg::OP_REPLACE_ADD_ONE)
			e.sd = s[15:0];
		mOvf = mOvf | s[16];
		if (c.op inside {acd_pkg::OP_ADD_A, acd_pkg::OP_SUBTRACT, acd_pkg::OP_INCREASE_A})
			mA = s[15:0];
		if (c.op inside {acd_pkg::OP_ADD_TO_Q, acd_pkg::OP_INCREASE_Q})
			mQ = s[15:0];
		// Inter-register results go to each selected register.
		case (c.op)
			acd_pkg::OP_SET_ONES:       w = 16'hffff;
			acd_pkg::OP_ZERO_REGISTERS: w = 16'h0000;
			acd_pkg::OP_COPY_A:         w = mA;
			acd_pkg::OP_COPY_Q:         w = mQ;
			acd_pkg::OP_COPY_NOT_A:     w = ~mA;
			acd_pkg::OP_COPY_NOT_Q:     w = ~mQ;
			acd_pkg::OP_SUM_A_Q:        w = s[15:0];
			acd_pkg::OP_XOR_A_Q:        w = mA ^ mQ;
			default:                    wr = 1'b0;
		endcase
		if (wr && c.destA)
			mA = w;
		if (wr && c.destQ)
			mQ = w;
		e.a = mA;
		e.q = mQ;
		e.ovf = mOvf;
		expQ.push_back(e);
	endtask : model

	// Waits at falling edges until ready is high, then offers one instruction to be taken at the next rising edge.
	task automatic issue(input acd_pkg::acd_cmd_t c);
		@(negedge clk);
		while (cmdReady !== 1'b1)
			@(negedge clk);
		cmdValid = 1'b1;
		cmd = c;
		model(c);
		@(posedge clk);
	endtask : issue

	// Loads full words into Q and then A.
	task automatic load(input logic [15:0] a, input logic [15:0] q);
		issue(mk(acd_pkg::OP_ZERO_REGISTERS));
		issue(mk(acd_pkg::OP_ADD_A, q));
		issue(mk(acd_pkg::OP_COPY_A, 16'h0000, 5'h00, 2'b01));
		issue(mk(acd_pkg::OP_ZERO_REGISTERS, 16'h0000, 5'h00, 2'b10));
		issue(mk(acd_pkg::OP_ADD_A, a));
	endtask : load

	task automatic finish_test(input string name);
		@(negedge clk);
		cmdValid = 1'b0;
		for (int i = 0; i < 64 && expQ.size() != 0; i++)
			@(negedge clk);
		// A result that never arrived counts against the run.
		if (expQ.size() != 0) begin
			check("pending results", expQ.size(), 32'h0000_0000);
			expQ.delete();
		end
		$display("test %s done", name);
	endtask : finish_test

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : print_verdict

	// Takes the oldest expectation whenever an instruction completes.
	always @(negedge clk) begin
		if (res.done === 1'b1 && expQ.size() == 0) begin
			check("unexpected done", 32'h0000_0001, 32'h0000_0000);
		end else if (res.done === 1'b1) begin
			nowExp = expQ.pop_front();
			check("regA", regA, nowExp.a);
			check("regQ", regQ, nowExp.q);
			check("overflow", overflowFlag, nowExp.ovf);
			check("skip", res.skip, nowExp.skip);
			check("storeValid", res.storeValid, nowExp.sv);
			if (nowExp.sv)
				check("storeData", res.storeData, nowExp.sd);
		end
	end

	// Watchdog cuts a hang short.
	initial begin
		repeat (30000) @(posedge clk);
		check("watchdog", 32'h0000_0001, 32'h0000_0000);
		print_verdict();
	end

	// Main sequence.
	initial begin
		rst_n = 1'b0;
		cmdValid = 1'b0;
		cmd = '0;
		{mA, mQ, mOvf} = '0;
		lfsr = 32'h0000_b607;
		v = 16'h0000;
		num_errors = 0;
		checks = 0;
		repeat (16) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		repeat (8) begin
			load(rnd(), rnd());
			issue(mk(acd_pkg::OP_SKIP_A_NEGATIVE));
			issue(mk(acd_pkg::OP_SKIP_Q_NEGATIVE));
			issue(mk(acd_pkg::OP_COPY_A, 16'h0000, 5'h00, 2'b01));
			issue(mk(acd_pkg::OP_SKIP_Q_NEGATIVE));
		end
		finish_test("sign skips");
		load(rnd(), rnd());
		issue(mk(acd_pkg::OP_SHIFT_A_LEFT, 16'h0000, 5'h10));
		issue(mk(acd_pkg::OP_SHIFT_Q_LEFT, 16'h0000, 5'h10));
		for (int n = 1; n < 32; n++)
			issue(mk(acd_pkg::OP_LONG_LEFT, 16'h0000, 5'(n)));
		load(16'h4000, 16'h0000);
		repeat (15) issue(mk(acd_pkg::OP_SHIFT_A_RIGHT, 16'h0000, 5'h01));
		load(16'h0800, 16'h0000);
		issue(mk(acd_pkg::OP_SHIFT_A_RIGHT, 16'h0000, 5'h02));
		repeat (10) issue(mk(acd_pkg::OP_SHIFT_A_RIGHT, 16'h0000, 5'h01));
		load(16'h8000, 16'h4000);
		repeat (31) issue(mk(acd_pkg::OP_LONG_RIGHT, 16'h0000, 5'h01));
		issue(mk(acd_pkg::OP_SET_ONES));
		finish_test("shifts");
		load(16'h7fff, 16'h0000);
		issue(mk(acd_pkg::OP_ADD_A, 16'h0001));
		issue(mk(acd_pkg::OP_SKIP_NO_OVERFLOW));
		issue(mk(acd_pkg::OP_SKIP_ON_OVERFLOW));
		issue(mk(acd_pkg::OP_SKIP_NO_OVERFLOW));
		issue(mk(acd_pkg::OP_SKIP_NO_OVERFLOW));
		load(16'h8000, 16'h0000);
		issue(mk(acd_pkg::OP_ADD_A, 16'hfffe));
		issue(mk(acd_pkg::OP_SKIP_ON_OVERFLOW));
		issue(mk(acd_pkg::OP_REPLACE_ADD_ONE, 16'h7ffe));
		issue(mk(acd_pkg::OP_REPLACE_ADD_ONE, 16'h7fff));
		issue(mk(acd_pkg::OP_SKIP_ON_OVERFLOW));
		issue(mk(acd_pkg::OP_DIVIDE_INTEGER, 16'h0000));
		issue(mk(acd_pkg::OP_SKIP_ON_OVERFLOW));
		load(16'h0000, 16'h4000);
		issue(mk(acd_pkg::OP_DIVIDE_INTEGER, 16'h0010));
		issue(mk(acd_pkg::OP_SKIP_ON_OVERFLOW));
		load(16'h1234, 16'h0001);
		issue(mk(acd_pkg::OP_DIVIDE_INTEGER, 16'h0100));
		issue(mk(acd_pkg::OP_SKIP_NO_OVERFLOW));
		finish_test("overflow");
		// Every operation with random words, fields, counts and selections.
		repeat (12) begin
			for (int k = 0; k < 31; k++) begin
				o = acd_pkg::acd_op_t'(5'(k));
				v = rnd();
				if (o inside {acd_pkg::OP_MULTIPLY_INTEGER, acd_pkg::OP_DIVIDE_INTEGER}) begin
					load(rnd() & 16'h7fff, (o == acd_pkg::OP_DIVIDE_INTEGER) ? 16'h0000 : rnd());
					v = v & 16'h00ff;
				end
				issue(mk(o, v, 5'(rnd()), 2'(rnd()), 8'(rnd())));
			end
		end
		finish_test("random sweep");
		print_verdict();
	end
endmodule : acd_datapath_tb_top
